// ==== hw/lscp_pkg.sv ====
// Purpose: Shared constants for the legacy system control ports
// Assumes: 8-bit host I/O data, port numbers on a 16-bit I/O address
// Notes: Ports are reached by plain I/O read and write strobes
package lscp_pkg;
    localparam logic [15:0] KBD_DATA_ADDR = 16'h0060;
    localparam logic [15:0] PORT_B_ADDR = 16'h0061;
    localparam logic [15:0] KBD_CMD_ADDR = 16'h0064;
    localparam logic [15:0] NMI_MASK_ADDR = 16'h0070;
    localparam logic [15:0] PORT_A_ADDR = 16'h0092;
    localparam logic [7:0] CMD_WRITE_OUTPORT = 8'hD1;
    localparam logic [7:0] DATA_A20_ON = 8'h02;
    localparam logic [7:0] CMD_FAST_RESET = 8'hFE;
    localparam logic [7:0] CMD_MASK_PIN_HIGH = 8'hAA;
    localparam int PB_PARITY_ERR = 7;
    localparam int PB_CHAN_ERR = 6;
    localparam int PB_TONE_OUT = 5;
    localparam int PB_REFRESH = 4;
    localparam int PB_CHAN_DIS = 3;
    localparam int PB_PARITY_DIS = 2;
    localparam int PB_SPK_EN = 1;
    localparam int PB_GATE = 0;
    localparam int NMI_MASK_BIT = 7;
    localparam int PA_A20_BIT = 1;
    localparam int PA_RESET_BIT = 0;
    localparam int CFG20_RESET_EN_BIT = 1;
    localparam logic [3:0] PB_CTRL_RESET = 4'h0;
    localparam logic [7:0] PA_RESET = 8'h00;
    localparam logic NMI_MASK_RESET = 1'b1;
    // Reset pulse length in ns at a 100 ns clock
    localparam int RESET_PULSE_NS = 400;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lscp_pkg

// ==== hw/lscp_pulse.sv ====
// Purpose: Fixed-length pulse stretcher for the fast processor reset
// Assumes: Trigger comes from logic on the same clock
// Notes: A trigger during a pulse restarts the count
`timescale 1ns/1ps
`default_nettype none
module lscp_pulse #(
    parameter int LEN = lscp_pkg::RESET_PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic trig_i,
    output logic pulse_o
);
    // The count lives in eight bits
    if (LEN < 1 || LEN > 255) begin : g_bad_len
        $error("lscp_pulse: LEN out of range");
    end
    logic [7:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else if (trig_i) begin
            cnt_q <= 8'(LEN);
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    assign pulse_o = (cnt_q != 8'h00);
    AST_PULSE_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
        (pulse_o && !trig_i) |=> (cnt_q == $past(cnt_q) - 8'h01))
        else $error("reset pulse count wrong");
endmodule : lscp_pulse
`default_nettype wire

// ==== hw/lscp_top.sv ====
// Purpose: Keyboard-port emulation, port B, NMI mask and port A
// Assumes: Host I/O strobes are one-cycle pulses on MCLK_I
// Notes: Port B, port A readable; other ports are write-only
// Function
// - D1h to 64h then 02h to 60h sets A20
// - Parity flag sets only while bit2 zero
// - Writing one to bit2 clears parity flag
// - Channel flag sets only while bit3 zero
// - Writing one to bit3 clears channel flag
// - Bit5 reads live tone counter output
// - Bit4 toggles on every refresh cycle
// - Channel check low raises NMI unless bit3
// - Parity error raises NMI unless bit2 set
// - Speaker is tone output AND bit1
// - Bit0 drives the tone counter gate
// - FEh to 64h pulses reset if enabled
// - AAh to 64h drives A20 mask high
// - Nmi_mask_port write-only NMI disable control
// - Port A bit1 drives fast A20 gate
// - Port A bit0 drives fast reset
`timescale 1ns/1ps
`default_nettype none
module lscp_top #(
    parameter int PULSE_LEN = lscp_pkg::RESET_PULSE_CYC
) (
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic [15:0] IO_ADDR_I,
    input wire logic [7:0] IO_WDATA_I,
    input wire logic IO_WR_I,
    input wire logic IO_RD_I,
    output logic [7:0] IO_RDATA_O,
    output logic IO_RD_HIT_O,
    input wire logic CFG20_I_BIT1_I,
    input wire logic TONE_COUNTER_OUTPUT_I,
    input wire logic REFRESH_I,
    input wire logic CHANNEL_CHECK_N_I,
    input wire logic PARITY_ERR_I,
    output logic TONE_COUNTER_GATE_O,
    output logic SPEAKER_OUT_O,
    output logic NMI_O,
    output logic FAST_A_TWENTY_GATE_O,
    output logic ADDR_BIT20_MASK_N_O,
    output logic CPU_RESET_O
);
    // Refuse pulse lengths the 8-bit counter cannot hold
    if (PULSE_LEN < 1 || PULSE_LEN > 255) begin : g_bad_len
        $error("lscp_top: PULSE_LEN out of range");
    end

    // Pin inputs pass two flops before any logic reads them
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    // Reset to idle pin levels, so no false refresh edge or reset enable follows reset
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            sync1_q <= 5'h10;
            sync2_q <= 5'h10;
        end else begin
            sync1_q <= {CHANNEL_CHECK_N_I, CFG20_I_BIT1_I, REFRESH_I, PARITY_ERR_I,
                        TONE_COUNTER_OUTPUT_I};
            sync2_q <= sync1_q;
        end
    end
    logic chk_n_s;
    logic cfg_rst_en_s;
    logic refresh_s;
    logic parity_s;
    logic tone_s;
    assign chk_n_s = sync2_q[4];
    assign cfg_rst_en_s = sync2_q[3];
    assign refresh_s = sync2_q[2];
    assign parity_s = sync2_q[1];
    assign tone_s = sync2_q[0];

    logic wr_kdata;
    logic wr_pb;
    logic wr_kcmd;
    logic wr_nmi;
    logic wr_pa;
    assign wr_kdata = IO_WR_I && (IO_ADDR_I == lscp_pkg::KBD_DATA_ADDR);
    assign wr_pb = IO_WR_I && (IO_ADDR_I == lscp_pkg::PORT_B_ADDR);
    assign wr_kcmd = IO_WR_I && (IO_ADDR_I == lscp_pkg::KBD_CMD_ADDR);
    assign wr_nmi = IO_WR_I && (IO_ADDR_I == lscp_pkg::NMI_MASK_ADDR);
    assign wr_pa = IO_WR_I && (IO_ADDR_I == lscp_pkg::PORT_A_ADDR);

    // Keyboard command sequencer
    typedef enum logic [1:0] {
        LSCP_IDLE = 2'b01,
        LSCP_WAIT_DATA = 2'b10
    } lscp_kbd_e;
    lscp_kbd_e kst_q;
    logic kbd_a20_q;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            kst_q <= LSCP_IDLE;
        end else if (wr_kcmd) begin
            kst_q <= (IO_WDATA_I == lscp_pkg::CMD_WRITE_OUTPORT) ? LSCP_WAIT_DATA : LSCP_IDLE;
        end else if (wr_kdata) begin
            kst_q <= LSCP_IDLE;
        end
    end
    // Data byte after the command sets or clears the gate, as a real controller would
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            kbd_a20_q <= 1'b0;
        end else if (wr_kdata) begin
            unique case (kst_q)
                LSCP_WAIT_DATA: begin
                    kbd_a20_q <= (IO_WDATA_I == lscp_pkg::DATA_A20_ON);
                end
                LSCP_IDLE: begin
                    kbd_a20_q <= kbd_a20_q;
                end
                default: begin
                    kbd_a20_q <= kbd_a20_q;
                end
            endcase
        end
    end

    // A20 mask pin idles low after reset until AAh arrives
    logic addr_mask_q;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            addr_mask_q <= 1'b0;
        end else if (wr_kcmd && IO_WDATA_I == lscp_pkg::CMD_MASK_PIN_HIGH) begin
            addr_mask_q <= 1'b1;
        end
    end
    assign ADDR_BIT20_MASK_N_O = addr_mask_q;

    // Port B control bits 3:0
    logic [3:0] pb_ctrl_q;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            pb_ctrl_q <= lscp_pkg::PB_CTRL_RESET;
        end else if (wr_pb) begin
            pb_ctrl_q <= IO_WDATA_I[3:0];
        end
    end
    logic chan_dis;
    logic par_dis;
    assign chan_dis = pb_ctrl_q[lscp_pkg::PB_CHAN_DIS - lscp_pkg::PB_GATE];
    assign par_dis = pb_ctrl_q[lscp_pkg::PB_PARITY_DIS - lscp_pkg::PB_GATE];
    assign TONE_COUNTER_GATE_O = pb_ctrl_q[lscp_pkg::PB_GATE];
    assign SPEAKER_OUT_O = tone_s & pb_ctrl_q[lscp_pkg::PB_SPK_EN];

    // Error flags: a write of one to the enable clears and beats a same-cycle set,
    // since the check is off from that edge on
    logic par_err_q;
    logic chan_err_q;
    logic pb_par_clr;
    logic pb_chan_clr;
    assign pb_par_clr = wr_pb && IO_WDATA_I[lscp_pkg::PB_PARITY_DIS];
    assign pb_chan_clr = wr_pb && IO_WDATA_I[lscp_pkg::PB_CHAN_DIS];
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            par_err_q <= 1'b0;
        end else if (parity_s && !par_dis && !pb_par_clr) begin
            par_err_q <= 1'b1;
        end else if (pb_par_clr) begin
            par_err_q <= 1'b0;
        end
    end
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            chan_err_q <= 1'b0;
        end else if (!chk_n_s && !chan_dis && !pb_chan_clr) begin
            chan_err_q <= 1'b1;
        end else if (pb_chan_clr) begin
            chan_err_q <= 1'b0;
        end
    end

    // Refresh toggle counts rising edges of the synchronised request
    logic refresh_d1_q;
    logic refresh_tgl_q;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            refresh_d1_q <= 1'b0;
            refresh_tgl_q <= 1'b0;
        end else begin
            refresh_d1_q <= refresh_s;
            if (refresh_s && !refresh_d1_q) begin
                refresh_tgl_q <= ~refresh_tgl_q;
            end
        end
    end

    // NMI mask starts set so no NMI fires before software is ready
    logic nmi_mask_q;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            nmi_mask_q <= lscp_pkg::NMI_MASK_RESET;
        end else if (wr_nmi) begin
            nmi_mask_q <= IO_WDATA_I[lscp_pkg::NMI_MASK_BIT];
        end
    end
    logic nmi_q;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= !nmi_mask_q && (par_err_q || chan_err_q);
        end
    end
    assign NMI_O = nmi_q;

    // Port A
    logic [7:0] pa_q;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            pa_q <= lscp_pkg::PA_RESET;
        end else if (wr_pa) begin
            pa_q <= IO_WDATA_I;
        end
    end
    assign FAST_A_TWENTY_GATE_O = pa_q[lscp_pkg::PA_A20_BIT] | kbd_a20_q;

    // Fast reset triggers
    logic rst_trig;
    assign rst_trig = (wr_kcmd && IO_WDATA_I == lscp_pkg::CMD_FAST_RESET && cfg_rst_en_s)
                      || (wr_pa && IO_WDATA_I[lscp_pkg::PA_RESET_BIT]
                          && !pa_q[lscp_pkg::PA_RESET_BIT]);
    lscp_pulse #(
        .LEN(PULSE_LEN)
    ) u_pulse (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .trig_i(rst_trig),
        .pulse_o(CPU_RESET_O)
    );

    // Read path, registered; ports 60h, 64h and 70h are write-only and never hit
    logic [7:0] rdata_q;
    logic rd_hit_q;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            rdata_q <= 8'h00;
            rd_hit_q <= 1'b0;
        end else begin
            rd_hit_q <= 1'b0;
            rdata_q <= 8'h00;
            if (IO_RD_I && IO_ADDR_I == lscp_pkg::PORT_B_ADDR) begin
                rd_hit_q <= 1'b1;
                rdata_q <= {par_err_q, chan_err_q, tone_s, refresh_tgl_q, pb_ctrl_q};
            end else if (IO_RD_I && IO_ADDR_I == lscp_pkg::PORT_A_ADDR) begin
                rd_hit_q <= 1'b1;
                rdata_q <= pa_q;
            end
        end
    end
    assign IO_RDATA_O = rdata_q;
    assign IO_RD_HIT_O = rd_hit_q;

    AST_A20_SEQ: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (kst_q == LSCP_WAIT_DATA && wr_kdata && IO_WDATA_I == lscp_pkg::DATA_A20_ON)
        |=> FAST_A_TWENTY_GATE_O)
        else $error("A20 gate not set by keyboard sequence");
    AST_PAR_SET_GATED: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        $rose(par_err_q) |-> $past(!par_dis))
        else $error("parity flag set while check disabled");
    AST_PAR_CLR: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        pb_par_clr |=> !par_err_q)
        else $error("parity flag not cleared");
    AST_CHAN_SET_GATED: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        $rose(chan_err_q) |-> $past(!chan_dis))
        else $error("channel flag set while check disabled");
    AST_CHAN_CLR: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        pb_chan_clr |=> !chan_err_q)
        else $error("channel flag not cleared");
    AST_REFRESH_TGL: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (refresh_s && !refresh_d1_q) |=> (refresh_tgl_q != $past(refresh_tgl_q)))
        else $error("refresh toggle missed");
    AST_SPEAKER: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        !pb_ctrl_q[lscp_pkg::PB_SPK_EN] |-> !SPEAKER_OUT_O)
        else $error("speaker not held low");
    AST_FAST_RESET: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (wr_kcmd && IO_WDATA_I == lscp_pkg::CMD_FAST_RESET && cfg_rst_en_s) |=> CPU_RESET_O)
        else $error("fast reset not pulsed");
    AST_NMI_MASKED: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        NMI_O |-> ($past(!nmi_mask_q) && $past(par_err_q || chan_err_q)))
        else $error("NMI without unmasked source");
    AST_ADDR_MASK: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (wr_kcmd && IO_WDATA_I == lscp_pkg::CMD_MASK_PIN_HIGH) |=> ADDR_BIT20_MASK_N_O [*2])
        else $error("A20 mask not high");
    // A set disable bit means its flag was cleared and cannot come back
    AST_PAR_IGNORED: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        par_dis |-> !par_err_q)
        else $error("parity flag held while check disabled");
    AST_CHAN_IGNORED: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        chan_dis |-> !chan_err_q)
        else $error("channel flag held while check disabled");
    AST_NMI_RAISE: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (!nmi_mask_q && (par_err_q || chan_err_q)) |=> NMI_O)
        else $error("NMI missing for unmasked source");
    AST_PORTA_RESET: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (wr_pa && IO_WDATA_I[lscp_pkg::PA_RESET_BIT] && !pa_q[lscp_pkg::PA_RESET_BIT])
        |=> CPU_RESET_O)
        else $error("port A reset not pulsed");
endmodule : lscp_top
`default_nettype wire

// ==== tb/lscp_host.sv ====
// Purpose: Host processor model issuing I/O writes and reads
// Assumes: One-cycle strobes; read data is taken the cycle after the strobe
// Notes: Idle address and data are inverted so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none
module lscp_host (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic hit_i,
    output var logic [15:0] addr_o,
    output var logic [7:0] wdata_o,
    output var logic wr_o,
    output var logic rd_o
);
    initial begin
        addr_o = 16'h0000;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : io_wr
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic h);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
        h = hit_i;
    endtask : io_rd
endmodule : lscp_host
`default_nettype wire

// ==== tb/test_legacy_system_control_ports.sv ====
// Purpose: Self-checking bench for the legacy system control ports
// Assumes: Level inputs pass two sync flops, so checks wait a few cycles
// Notes: Reset pulse length shortened to 3 cycles to prove the parameter
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module test_legacy_system_control_ports;
    localparam int PLEN = 3;
    logic clk = 1'b0, rst = 1'b1, wr, rd, hit, cfg = 1'b0, tone = 1'b0, refr = 1'b0;
    logic chk_n = 1'b1, par = 1'b0, gate, spk, nmi, a20, mask_n, cpurst;
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    int err_count = 0, cmp_count = 0;
    always #50 clk = ~clk;
    lscp_host host (.clk_i(clk), .rdata_i(rdata), .hit_i(hit), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    lscp_top #(.PULSE_LEN(PLEN)) uut (.MCLK_I(clk), .SYS_RST_I(rst), .IO_ADDR_I(addr),
        .IO_WDATA_I(wdata), .IO_WR_I(wr), .IO_RD_I(rd), .IO_RDATA_O(rdata),
        .IO_RD_HIT_O(hit), .CFG20_I_BIT1_I(cfg), .TONE_COUNTER_OUTPUT_I(tone),
        .REFRESH_I(refr), .CHANNEL_CHECK_N_I(chk_n), .PARITY_ERR_I(par),
        .TONE_COUNTER_GATE_O(gate), .SPEAKER_OUT_O(spk), .NMI_O(nmi),
        .FAST_A_TWENTY_GATE_O(a20), .ADDR_BIT20_MASK_N_O(mask_n), .CPU_RESET_O(cpurst));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e,
        input logic eh);
        logic [7:0] d;
        logic h;
        host.io_rd(a, d, h);
        `CHK(h, eh)
        `CHK(d & m, e)
    endtask : rdc
    task automatic pulse_count(input int e);
        int n;
        n = 0;
        repeat (10) begin
            if (cpurst === 1'b1) n++;
            cyc(1);
        end
        `CHK(n, e)
    endtask : pulse_count
    task automatic t_reset;
        `CHK({nmi, a20, mask_n, cpurst, gate, spk}, 6'h00)
        rdc(16'h0061, 8'hFF, 8'h00, 1'b1);
        rdc(16'h0092, 8'hFF, 8'h00, 1'b1);
        rdc(16'h0064, 8'hFF, 8'h00, 1'b0);
        rdc(16'h0050, 8'hFF, 8'h00, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_portb;
        tone = 1'b1;
        cyc(4);
        host.io_wr(16'h0061, 8'h03);
        `CHK({gate, spk}, 2'b11)
        rdc(16'h0061, 8'h2F, 8'h23, 1'b1);
        tone = 1'b0;
        cyc(4);
        `CHK(spk, 1'b0)
        rdc(16'h0061, 8'h20, 8'h00, 1'b1);
        host.io_wr(16'h0061, 8'h01);
        tone = 1'b1;
        cyc(4);
        `CHK({gate, spk}, 2'b10)
        host.io_wr(16'h0061, 8'h00);
        `CHK(gate, 1'b0)
        $display("test port b done");
    endtask : t_portb
    task automatic t_refresh;
        for (int i = 1; i <= 4; i++) begin
            refr = 1'b1;
            cyc(4);
            refr = 1'b0;
            cyc(4);
            rdc(16'h0061, 8'h10, (i % 2 == 1) ? 8'h10 : 8'h00, 1'b1);
        end
        $display("test refresh done");
    endtask : t_refresh
    task automatic t_errors;
        host.io_wr(16'h0070, 8'h00);
        par = 1'b1;
        cyc(4);
        rdc(16'h0061, 8'hC0, 8'h80, 1'b1);
        `CHK(nmi, 1'b1)
        host.io_wr(16'h0061, 8'h04);
        cyc(3);
        rdc(16'h0061, 8'hC0, 8'h00, 1'b1);
        `CHK(nmi, 1'b0)
        par = 1'b0;
        host.io_wr(16'h0061, 8'h00);
        chk_n = 1'b0;
        cyc(4);
        rdc(16'h0061, 8'hC0, 8'h40, 1'b1);
        `CHK(nmi, 1'b1)
        host.io_wr(16'h0070, 8'h80);
        cyc(2);
        `CHK(nmi, 1'b0)
        host.io_wr(16'h0070, 8'h7F);
        cyc(2);
        `CHK(nmi, 1'b1)
        host.io_wr(16'h0061, 8'h08);
        cyc(3);
        `CHK(nmi, 1'b0)
        rdc(16'h0061, 8'hC0, 8'h00, 1'b1);
        chk_n = 1'b1;
        host.io_wr(16'h0061, 8'h00);
        $display("test errors done");
    endtask : t_errors
    task automatic t_kbd;
        host.io_wr(16'h0064, 8'hAA);
        `CHK(mask_n, 1'b1)
        host.io_wr(16'h0064, 8'hD1);
        `CHK(a20, 1'b0)
        host.io_wr(16'h0060, 8'h02);
        `CHK(a20, 1'b1)
        host.io_wr(16'h0064, 8'hD1);
        host.io_wr(16'h0060, 8'h00);
        `CHK(a20, 1'b0)
        host.io_wr(16'h0064, 8'hFE);
        pulse_count(0);
        cfg = 1'b1;
        cyc(4);
        host.io_wr(16'h0064, 8'hFE);
        pulse_count(PLEN);
        host.io_wr(16'h0092, 8'h02);
        `CHK(a20, 1'b1)
        rdc(16'h0092, 8'hFF, 8'h02, 1'b1);
        host.io_wr(16'h0092, 8'h01);
        pulse_count(PLEN);
        `CHK(a20, 1'b0)
        $display("test keyboard and port a done");
    endtask : t_kbd
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #(3000 * 100);
        err_count++;
        wrap_up();
    end
    initial begin
        cyc(6);
        rst = 1'b0;
        t_reset();
        t_portb();
        t_refresh();
        t_errors();
        t_kbd();
        wrap_up();
    end
endmodule : test_legacy_system_control_ports
`default_nettype wire
